// ---- rtl/sthu_uart.sv ----
/*
  Serial terminal UART with process image handshake, FIFOs and flow control.
  Assumes process image inputs and the receive line are synchronous to
  i_core_clk and i_bus_cycle pulses once per fieldbus cycle.
*/
// Notes on behaviour
// - Low baud byte 0xFF gives rate 4 MHz / (16 * (high byte + 1)).
// - Frame bits 2..0 choose 7E, 7O, 8N (default), 8E or 8O.
// - Frame bit 3 chooses one stop bit (default) or two.
// - Feature bit 1 picks standard or alternative image format, alternative default.
// - Feature bit 2 delays the status byte by one bus cycle.
// - Feature bit 3: stop sending on 0x13 from partner, resume on 0x11.
// - Feature bit 4: send 0x13 at 118 buffered, 0x11 below 18 after.
// - Feature bit 5: zero releases driver when idle, one drives always.
// - Mapped byte count 1 to 5, default 3.
// - Status byte holds in count, buffer full, init ack, offer, send ack.
// - Send toggle change copies out count bytes to send FIFO, then acks.
// - Received bytes are offered with in count and a toggled offer bit.
// - No new block is offered before the controller's ack matches.
// - Init request stops link, clears FIFOs, reloads settings, raises init ack.
// - Init request low makes the device clear init ack.
// - Full receive FIFO sets buffer full and drops new characters.
// - Characters with parity or framing errors are dropped.
// - Parity, framing and overflow errors set their diagnostic bits; overrun bit stays zero.
// - Diagnostic bits: overflow 0, parity 1, framing 2, overrun 3, full 4.
// - Buffer full flag asserts at the programmable threshold, default 0x80.
// - Control bit 7 set means register access; standard format ignores handshake bits, alternative format only holds new offers.
`timescale 1ns/1ps

module sthu_fifo #(
  parameter int W = 8,
  parameter int D = 2,
  localparam int AW = (D > 1) ? $clog2(D) : 1,
  localparam int CW = $clog2(D + 1)
) (
  input wire logic i_core_clk, // Core clock
  input wire logic i_resetn, // Async reset, active low
  input wire logic i_clear, // Empty the buffer
  input wire logic [W-1:0] i_data, // Write data
  input wire logic i_valid, // Write request
  output logic o_ready, // Room for a word
  output logic [W-1:0] o_data, // Head word
  output logic o_valid, // Head word present
  input wire logic i_ready, // Head word taken
  output logic [CW-1:0] o_count // Occupancy
);
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic push, pop;

  assign o_ready = cnt_q != CW'(D);
  assign o_valid = cnt_q != '0;
  assign o_data = mem_q[rd_q];
  assign o_count = cnt_q;
  assign push = i_valid & o_ready;
  assign pop = i_ready & o_valid;

  always_comb begin
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (i_clear) begin
      wr_d = '0;
      rd_d = '0;
      cnt_d = '0;
    end else begin
      if (push) wr_d = (wr_q == AW'(D - 1)) ? '0 : wr_q + 1'b1;
      if (pop) rd_d = (rd_q == AW'(D - 1)) ? '0 : rd_q + 1'b1;
      cnt_d = cnt_q + CW'(push) - CW'(pop);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      if (push && !i_clear) mem_q[wr_q] <= i_data;
    end
  end
endmodule : sthu_fifo

module sthu_uart import sthu_pkg::*; #(
  parameter int RX_DEPTH = 128,
  parameter int TX_DEPTH = 16
) (
  input wire logic i_core_clk, // Core clock, 25 MHz
  input wire logic i_resetn, // Async reset, active low
  input wire logic i_bus_cycle, // Process image exchange strobe
  input wire sthu_pi_out_t i_pi, // Output image from controller
  output sthu_pi_in_t o_pi, // Input image to controller
  input wire logic i_rxd, // Receive line
  output logic o_txd, // Transmit line value
  output logic o_txd_oe_n // Transmit driver enable, low drives
);
  localparam int RCW = $clog2(RX_DEPTH + 1);
  localparam int TCW = $clog2(TX_DEPTH + 1);
  typedef enum logic [2:0] {S_IDLE, S_START, S_DATA, S_PAR, S_STOP} sthu_ser_t;

  logic [15:0] thr_q, thr_d, baud_q, baud_d, frame_q, frame_d;
  logic [15:0] feat_q, feat_d, map_q, map_d, act_baud_q, act_baud_d;
  logic [7:0] act_thr_q, act_thr_d, act_frame_q, act_frame_d;
  logic [7:0] act_feat_q, act_feat_d, act_map_q, act_map_d;
  logic [4:0] diag_q, diag_d;
  logic [4:0] acc_q, acc_d;
  logic [7:0] div_q, div_d, div_top;
  logic ref_tick, tick16;
  logic [7:0] hs, rd_val_lo, rd_val_hi;
  logic reg_mode, hs_ok, init_req, tx_clr;
  logic [15:0] rd_val;
  logic f8, fpar, fodd, buf_full;
  logic [7:0] tf_wdata, tf_rdata, tb_rdata, rf_rdata;
  logic tf_wvalid, tf_wready, tf_rvalid, tb_ready, tb_valid, tb_take;
  logic rf_ready, rf_valid, rf_push, rf_pop;
  logic [TCW-1:0] tf_cnt;
  logic [RCW-1:0] rf_cnt;

  // Register access through the control byte, written once per bus cycle
  assign reg_mode = i_pi.ctrl[CB_REG];
  assign hs = act_feat_q[FEAT_ALT] ? i_pi.ser_ctrl : i_pi.ctrl;
  assign hs_ok = !hs[CB_REG] && !(reg_mode && !act_feat_q[FEAT_ALT]);
  assign init_req = hs_ok && hs[CB_INIT];

  always_comb begin
    rd_val = '0;
    case (i_pi.ctrl[5:0])
      ADR_TX_CNT: rd_val = 16'(tf_cnt);
      ADR_RX_CNT: rd_val = 16'(rf_cnt);
      ADR_DIAG: rd_val = {11'h000, diag_q};
      ADR_THR: rd_val = thr_q;
      ADR_BAUD: rd_val = baud_q;
      ADR_FRAME: rd_val = frame_q;
      ADR_FEAT: rd_val = feat_q;
      ADR_MAP: rd_val = map_q;
      default: rd_val = '0;
    endcase
  end
  assign rd_val_lo = rd_val[7:0];
  assign rd_val_hi = rd_val[15:8];

  always_comb begin
    thr_d = thr_q;
    baud_d = baud_q;
    frame_d = frame_q;
    feat_d = feat_q;
    map_d = map_q;
    if (i_bus_cycle && reg_mode && i_pi.ctrl[CB_WR]) begin
      case (i_pi.ctrl[5:0])
        ADR_THR: thr_d = {i_pi.data[1], i_pi.data[0]};
        ADR_BAUD: baud_d = {i_pi.data[1], i_pi.data[0]};
        ADR_FRAME: frame_d = {i_pi.data[1], i_pi.data[0]};
        ADR_FEAT: feat_d = {i_pi.data[1], i_pi.data[0]};
        ADR_MAP: map_d = {i_pi.data[1], i_pi.data[0]};
        default: thr_d = thr_q;
      endcase
    end
    act_thr_d = act_thr_q;
    act_baud_d = act_baud_q;
    act_frame_d = act_frame_q;
    act_feat_d = act_feat_q;
    act_map_d = act_map_q;
    if (init_req) begin
      act_thr_d = thr_q[7:0];
      act_baud_d = baud_q;
      act_frame_d = frame_q[7:0];
      act_feat_d = feat_q[7:0];
      act_map_d = (map_q[7:0] == 8'h00) ? 8'h01 :
                  (map_q[7:0] > 8'(MAX_BYTES)) ? 8'(MAX_BYTES) : map_q[7:0];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      thr_q <= RST_THR;
      baud_q <= RST_BAUD;
      frame_q <= RST_FRAME;
      feat_q <= RST_FEAT;
      map_q <= RST_MAP;
      act_thr_q <= RST_THR[7:0];
      act_baud_q <= RST_BAUD;
      act_frame_q <= RST_FRAME[7:0];
      act_feat_q <= RST_FEAT[7:0];
      act_map_q <= RST_MAP[7:0];
    end else begin
      thr_q <= thr_d;
      baud_q <= baud_d;
      frame_q <= frame_d;
      feat_q <= feat_d;
      map_q <= map_d;
      act_thr_q <= act_thr_d;
      act_baud_q <= act_baud_d;
      act_frame_q <= act_frame_d;
      act_feat_q <= act_feat_d;
      act_map_q <= act_map_d;
    end
  end

  // 4 MHz reference by fractional accumulation, then the 16x bit tick
  assign div_top = (act_baud_q[7:0] == BAUD_DIRECT) ? act_baud_q[15:8] :
                   sthu_baud_div(act_baud_q[2:0]);
  assign ref_tick = (acc_q + 5'(REF_STEP)) >= 5'(REF_MOD);
  assign tick16 = ref_tick && div_q >= div_top;
  always_comb begin
    acc_d = ref_tick ? acc_q + 5'(REF_STEP) - 5'(REF_MOD)
                     : acc_q + 5'(REF_STEP);
    div_d = div_q;
    if (ref_tick) div_d = tick16 ? 8'h00 : div_q + 8'h01;
  end
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      acc_q <= '0;
      div_q <= '0;
    end else begin
      acc_q <= acc_d;
      div_q <= div_d;
    end
  end

  assign f8 = act_frame_q[2] || act_frame_q[2:0] == FRM_8N;
  assign fpar = act_frame_q[2:0] inside {FRM_7E, FRM_7O, FRM_8E, FRM_8O};
  assign fodd = act_frame_q[2:0] inside {FRM_7O, FRM_8O};
  assign tx_clr = init_req;

  sthu_ser_t tx_st_q, tx_st_d, rx_st_q, rx_st_d;
  logic [7:0] tx_sh_q, tx_sh_d, rx_sh_q, rx_sh_d;
  logic [3:0] tx_tk_q, tx_tk_d, rx_tk_q, rx_tk_d;
  logic [2:0] tx_bit_q, tx_bit_d, rx_bit_q, rx_bit_d;
  logic tx_stp_q, tx_stp_d, txd_q, txd_d, oen_q, oen_d;
  logic paused_q, paused_d, xoff_q, xoff_d, rx_perr_q, rx_perr_d;
  logic xoff_need, xon_need, rx_done, rx_ferr;
  logic [7:0] tx_load;

  // Send FIFO, then the two-entry buffer in front of the transmitter
  sthu_fifo #(.W(8), .D(TX_DEPTH)) u_tx_fifo (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_clear(tx_clr),
    .i_data(tf_wdata), .i_valid(tf_wvalid), .o_ready(tf_wready),
    .o_data(tf_rdata), .o_valid(tf_rvalid), .i_ready(tb_ready),
    .o_count(tf_cnt));
  sthu_fifo #(.W(8), .D(2)) u_tx_buf (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_clear(tx_clr),
    .i_data(tf_rdata), .i_valid(tf_rvalid), .o_ready(tb_ready),
    .o_data(tb_rdata), .o_valid(tb_valid), .i_ready(tb_take),
    .o_count());
  sthu_fifo #(.W(8), .D(RX_DEPTH)) u_rx_fifo (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_clear(tx_clr),
    .i_data(rx_sh_q), .i_valid(rf_push), .o_ready(rf_ready),
    .o_data(rf_rdata), .o_valid(rf_valid), .i_ready(rf_pop),
    .o_count(rf_cnt));

  // Transmitter
  assign xoff_need = act_feat_q[FEAT_RXFLOW] && !xoff_q &&
                     rf_cnt >= RCW'(XOFF_LEVEL);
  assign xon_need = act_feat_q[FEAT_RXFLOW] && xoff_q &&
                    rf_cnt < RCW'(XON_LEVEL);
  assign tb_take = tx_st_q == S_IDLE && !init_req && !xoff_need &&
                   !xon_need && !paused_q;
  assign tx_load = xoff_need ? CHR_XOFF : xon_need ? CHR_XON : tb_rdata;

  always_comb begin
    tx_st_d = tx_st_q;
    tx_sh_d = tx_sh_q;
    tx_tk_d = tx_tk_q;
    tx_bit_d = tx_bit_q;
    tx_stp_d = tx_stp_q;
    xoff_d = init_req ? 1'b0 : xoff_q;
    case (tx_st_q)
      S_IDLE: begin
        if (!init_req && (xoff_need || xon_need || (tb_take && tb_valid)))
        begin
          tx_st_d = S_START;
          tx_sh_d = tx_load;
          tx_tk_d = '0;
          if (xoff_need) xoff_d = 1'b1;
          else if (xon_need) xoff_d = 1'b0;
        end
      end
      S_START, S_DATA, S_PAR, S_STOP: begin
        if (tick16) tx_tk_d = tx_tk_q + 4'h1;
        if (tick16 && tx_tk_q == 4'(OVERSAMPLE - 1)) begin
          case (tx_st_q)
            S_START: begin
              tx_st_d = S_DATA;
              tx_bit_d = '0;
            end
            S_DATA: begin
              tx_bit_d = tx_bit_q + 3'h1;
              if (tx_bit_q == (f8 ? 3'h7 : 3'h6)) begin
                tx_st_d = fpar ? S_PAR : S_STOP;
                tx_stp_d = act_frame_q[FRAME_STOP2];
              end
            end
            S_PAR: tx_st_d = S_STOP;
            default: begin
              tx_stp_d = 1'b0;
              if (!tx_stp_q) tx_st_d = S_IDLE;
            end
          endcase
        end
      end
      default: tx_st_d = S_IDLE;
    endcase
    if (init_req) tx_st_d = S_IDLE;
    case (tx_st_q)
      S_START: txd_d = 1'b0;
      S_DATA: txd_d = tx_sh_q[tx_bit_q];
      S_PAR: txd_d = (f8 ? ^tx_sh_q : ^tx_sh_q[6:0]) ^ fodd;
      default: txd_d = 1'b1;
    endcase
    oen_d = !act_feat_q[FEAT_P2P] && tx_st_q == S_IDLE;
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_st_q <= S_IDLE;
      tx_sh_q <= '0;
      tx_tk_q <= '0;
      tx_bit_q <= '0;
      tx_stp_q <= 1'b0;
      xoff_q <= 1'b0;
      txd_q <= 1'b1;
      oen_q <= 1'b1;
    end else begin
      tx_st_q <= tx_st_d;
      tx_sh_q <= tx_sh_d;
      tx_tk_q <= tx_tk_d;
      tx_bit_q <= tx_bit_d;
      tx_stp_q <= tx_stp_d;
      xoff_q <= xoff_d;
      txd_q <= txd_d;
      oen_q <= oen_d;
    end
  end
  assign o_txd = txd_q;
  assign o_txd_oe_n = oen_q;

  // Receiver samples mid-bit on the 16x tick
  assign rx_done = tick16 && rx_st_q == S_STOP && rx_tk_q == 4'(OVERSAMPLE - 1);
  assign rx_ferr = !i_rxd;
  assign rf_push = rx_done && !rx_ferr && !rx_perr_q &&
                   !(act_feat_q[FEAT_TXFLOW] &&
                     (rx_sh_q == CHR_XOFF || rx_sh_q == CHR_XON));
  assign buf_full = rf_cnt >= RCW'(act_thr_q);

  always_comb begin
    rx_st_d = rx_st_q;
    rx_sh_d = rx_sh_q;
    rx_tk_d = rx_tk_q;
    rx_bit_d = rx_bit_q;
    rx_perr_d = rx_perr_q;
    paused_d = init_req ? 1'b0 : paused_q;
    diag_d = init_req ? 5'h00 : diag_q;
    if (tick16) rx_tk_d = rx_tk_q + 4'h1;
    case (rx_st_q)
      S_IDLE: begin
        rx_tk_d = '0;
        rx_perr_d = 1'b0;
        if (tick16 && !i_rxd) rx_st_d = S_START;
      end
      S_START: begin
        if (tick16 && rx_tk_q == 4'(OVERSAMPLE / 2 - 2)) begin
          rx_tk_d = '0;
          rx_bit_d = '0;
          rx_st_d = i_rxd ? S_IDLE : S_DATA;
        end
      end
      S_DATA: begin
        if (tick16 && rx_tk_q == 4'(OVERSAMPLE - 1)) begin
          rx_sh_d = {i_rxd, rx_sh_q[7:1]};
          rx_bit_d = rx_bit_q + 3'h1;
          if (rx_bit_q == (f8 ? 3'h7 : 3'h6)) begin
            rx_st_d = fpar ? S_PAR : S_STOP;
            if (!f8) rx_sh_d = {1'b0, i_rxd, rx_sh_q[7:2]};
          end
        end
      end
      S_PAR: begin
        if (tick16 && rx_tk_q == 4'(OVERSAMPLE - 1)) begin
          rx_perr_d = ((f8 ? ^rx_sh_q : ^rx_sh_q[6:0]) ^ fodd) != i_rxd;
          rx_st_d = S_STOP;
        end
      end
      S_STOP: if (rx_done) rx_st_d = S_IDLE;
      default: rx_st_d = S_IDLE;
    endcase
    if (rx_done) begin
      if (rx_perr_q) diag_d[DG_PAR] = 1'b1;
      if (rx_ferr) diag_d[DG_FRM] = 1'b1;
      if (rf_push && !rf_ready) diag_d[DG_OVFL] = 1'b1;
      if (act_feat_q[FEAT_TXFLOW] && !rx_ferr && !rx_perr_q) begin
        if (rx_sh_q == CHR_XOFF) paused_d = 1'b1;
        if (rx_sh_q == CHR_XON) paused_d = 1'b0;
      end
    end
    diag_d[DG_FULL] = buf_full;
    diag_d[DG_OVR] = 1'b0;
    if (init_req) rx_st_d = S_IDLE;
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_st_q <= S_IDLE;
      rx_sh_q <= '0;
      rx_tk_q <= '0;
      rx_bit_q <= '0;
      rx_perr_q <= 1'b0;
      paused_q <= 1'b0;
      diag_q <= '0;
    end else begin
      rx_st_q <= rx_st_d;
      rx_sh_q <= rx_sh_d;
      rx_tk_q <= rx_tk_d;
      rx_bit_q <= rx_bit_d;
      rx_perr_q <= rx_perr_d;
      paused_q <= paused_d;
      diag_q <= diag_d;
    end
  end

  // Handshake: block copy into the send FIFO and block offer from receive
  logic ack_q, ack_d, off_q, off_d, iack_q, iack_d, cp_q, cp_d, rd_q, rd_d;
  logic [2:0] cp_i_q, cp_i_d, cp_n_q, cp_n_d, rd_i_q, rd_i_d, rd_n_q, rd_n_d;
  logic [2:0] in_cnt_q, in_cnt_d, oc;
  logic [MAX_BYTES-1:0][7:0] in_q, in_d;
  logic [7:0] hs_stat, stat_prev_q, stat_prev_d;
  sthu_pi_in_t pi_q, pi_d;

  assign oc = (hs[6:4] > 3'(MAX_BYTES)) ? 3'(MAX_BYTES) : hs[6:4];
  assign tf_wvalid = cp_q;
  assign tf_wdata = i_pi.data[cp_i_q];
  assign rf_pop = rd_q;

  always_comb begin
    ack_d = ack_q;
    off_d = off_q;
    cp_d = cp_q;
    cp_i_d = cp_i_q;
    cp_n_d = cp_n_q;
    rd_d = rd_q;
    rd_i_d = rd_i_q;
    rd_n_d = rd_n_q;
    in_cnt_d = in_cnt_q;
    in_d = in_q;
    iack_d = init_req ? 1'b1 : (hs_ok ? 1'b0 : iack_q);
    if (cp_q && tf_wready) begin
      cp_i_d = cp_i_q + 3'h1;
      if (cp_i_q == cp_n_q - 3'h1) begin
        cp_d = 1'b0;
        ack_d = ~ack_q;
      end
    end else if (!cp_q && hs_ok && !init_req && hs[CB_TREQ] != ack_q &&
                 TCW'(TX_DEPTH) - tf_cnt >= TCW'(oc)) begin
      cp_i_d = '0;
      cp_n_d = oc;
      if (oc == 3'h0) ack_d = hs[CB_TREQ];
      else cp_d = 1'b1;
    end
    if (rd_q) begin
      in_d[rd_i_q] = rf_rdata;
      rd_i_d = rd_i_q + 3'h1;
      if (rd_i_q == rd_n_q - 3'h1) begin
        rd_d = 1'b0;
        in_cnt_d = rd_n_q;
        off_d = ~off_q;
      end
    end else if (hs_ok && !init_req && !reg_mode && rf_valid &&
                 hs[CB_RACK] == off_q) begin
      rd_d = 1'b1;
      rd_i_d = '0;
      rd_n_d = (rf_cnt < RCW'(act_map_q)) ? 3'(rf_cnt) : 3'(act_map_q);
    end
    if (init_req) begin
      in_cnt_d = '0;
      cp_d = 1'b0;
      rd_d = 1'b0;
      ack_d = hs[CB_TREQ];
      off_d = hs[CB_RACK];
    end
    hs_stat = {1'b0, in_cnt_q, buf_full, iack_q, off_q, ack_q};
    stat_prev_d = i_bus_cycle ? hs_stat : stat_prev_q;
    pi_d = pi_q;
    if (i_bus_cycle) begin
      pi_d.data = in_q;
      pi_d.stat = reg_mode ? i_pi.ctrl : 8'h00;
      pi_d.ser_stat = act_feat_q[FEAT_STDLY] ? stat_prev_q : hs_stat;
      if (!act_feat_q[FEAT_ALT]) begin
        if (!reg_mode) pi_d.stat = pi_d.ser_stat;
        pi_d.ser_stat = 8'h00;
      end
      if (reg_mode) begin
        pi_d.data[0] = rd_val_lo;
        pi_d.data[1] = rd_val_hi;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ack_q <= 1'b0;
      off_q <= 1'b0;
      iack_q <= 1'b0;
      cp_q <= 1'b0;
      cp_i_q <= '0;
      cp_n_q <= '0;
      rd_q <= 1'b0;
      rd_i_q <= '0;
      rd_n_q <= '0;
      in_cnt_q <= '0;
      in_q <= '0;
      stat_prev_q <= '0;
      pi_q <= '0;
    end else begin
      ack_q <= ack_d;
      off_q <= off_d;
      iack_q <= iack_d;
      cp_q <= cp_d;
      cp_i_q <= cp_i_d;
      cp_n_q <= cp_n_d;
      rd_q <= rd_d;
      rd_i_q <= rd_i_d;
      rd_n_q <= rd_n_d;
      in_cnt_q <= in_cnt_d;
      in_q <= in_d;
      stat_prev_q <= stat_prev_d;
      pi_q <= pi_d;
    end
  end
  assign o_pi = pi_q;
endmodule : sthu_uart

// ---- rtl/sthu_pkg.sv ----
/*
  Shared constants and types of the serial terminal with handshake UART.
  Assumes a 25 MHz core clock and a 4 MHz baud reference derived from it.
*/
package sthu_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int REF_HZ = 4_000_000;
  localparam int REF_MOD = CLK_HZ / 1_000_000;
  localparam int REF_STEP = REF_HZ / 1_000_000;
  localparam int OVERSAMPLE = 16;
  localparam int MAX_BYTES = 5;
  // Register indices reached through the control byte in register mode
  localparam logic [5:0] ADR_TX_CNT = 6'h00;
  localparam logic [5:0] ADR_RX_CNT = 6'h01;
  localparam logic [5:0] ADR_DIAG = 6'h06;
  localparam logic [5:0] ADR_THR = 6'h12;
  localparam logic [5:0] ADR_BAUD = 6'h20;
  localparam logic [5:0] ADR_FRAME = 6'h21;
  localparam logic [5:0] ADR_FEAT = 6'h22;
  localparam logic [5:0] ADR_MAP = 6'h23;
  localparam logic [15:0] RST_THR = 16'h0080;
  localparam logic [15:0] RST_BAUD = 16'h0006;
  localparam logic [15:0] RST_FRAME = 16'h0003;
  localparam logic [15:0] RST_FEAT = 16'h0003;
  localparam logic [15:0] RST_MAP = 16'h0003;
  localparam logic [7:0] BAUD_DIRECT = 8'hFF;
  localparam logic [7:0] CHR_XOFF = 8'h13;
  localparam logic [7:0] CHR_XON = 8'h11;
  localparam int XOFF_LEVEL = 118;
  localparam int XON_LEVEL = 18;
  localparam int FEAT_ALT = 1;
  localparam int FEAT_STDLY = 2;
  localparam int FEAT_TXFLOW = 3;
  localparam int FEAT_RXFLOW = 4;
  localparam int FEAT_P2P = 5;
  localparam int FRAME_STOP2 = 3;
  localparam logic [2:0] FRM_7E = 3'h1;
  localparam logic [2:0] FRM_7O = 3'h2;
  localparam logic [2:0] FRM_8N = 3'h3;
  localparam logic [2:0] FRM_8E = 3'h4;
  localparam logic [2:0] FRM_8O = 3'h5;
  localparam int CB_REG = 7;
  localparam int CB_WR = 6;
  localparam int CB_INIT = 2;
  localparam int CB_RACK = 1;
  localparam int CB_TREQ = 0;
  localparam int DG_OVFL = 0;
  localparam int DG_PAR = 1;
  localparam int DG_FRM = 2;
  localparam int DG_OVR = 3;
  localparam int DG_FULL = 4;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] ser_ctrl;
    logic [MAX_BYTES-1:0][7:0] data;
  } sthu_pi_out_t;

  typedef struct packed {
    logic [7:0] stat;
    logic [7:0] ser_stat;
    logic [MAX_BYTES-1:0][7:0] data;
  } sthu_pi_in_t;

  // Oversample divisor minus one for the coded rates 1200..19200
  function automatic logic [7:0] sthu_baud_div(input logic [2:0] code);
    case (code)
      3'h3: sthu_baud_div = 8'hCF;
      3'h4: sthu_baud_div = 8'h67;
      3'h5: sthu_baud_div = 8'h33;
      3'h7: sthu_baud_div = 8'h0C;
      default: sthu_baud_div = 8'h19;
    endcase
  endfunction : sthu_baud_div
endpackage : sthu_pkg

// ---- test/sthu_uart_properties.sv ----
/* Port checker of sthu_uart.
   Assumes one clock and single-cycle bus strobes. */
`timescale 1ns/1ps
module sthu_uart_properties import sthu_pkg::*; (
  input wire logic i_core_clk, // Clock
  input wire logic i_resetn, // Reset
  input wire logic i_bus_cycle, // Strobe
  input wire sthu_pi_out_t i_pi, // Output image
  input wire sthu_pi_in_t o_pi, // Input image
  input wire logic i_rxd, // Receive line
  input wire logic o_txd, // Transmit line
  input wire logic o_txd_oe_n // Driver enable
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  AST_PI_HOLD:
    assert property (!$past(i_bus_cycle) |-> $stable(o_pi))
    else $error("image moved");
  AST_REG_ECHO:
    assert property (i_bus_cycle && i_pi.ctrl[7]
      |=> o_pi.stat == $past(i_pi.ctrl)) else $error("no echo");
  AST_STAT_FMT:
    assert property (!o_pi.ser_stat[7] && o_pi.ser_stat[6:4] <= 3'h5)
    else $error("bad status");
  AST_TX_DRIVEN:
    assert property ($fell(o_txd) |-> !o_txd_oe_n)
    else $error("undriven edge");
  AST_TX_IDLE:
    assert property (o_txd_oe_n |-> o_txd) else $error("released low");
  AST_SEND_ACK:
    assert property ($changed(o_pi.ser_stat[0])
      |-> o_pi.ser_stat[0] == $past(i_pi.ser_ctrl[0])) else $error("ack");
  AST_OFFER_WAIT:
    assert property ($changed(o_pi.ser_stat[1]) && !o_pi.ser_stat[2]
      |-> $past(i_pi.ser_ctrl[1]) != o_pi.ser_stat[1]) else $error("offer");
  AST_OFFER_CNT:
    assert property ($changed(o_pi.ser_stat[1]) && !o_pi.ser_stat[2]
      |-> o_pi.ser_stat[6:4] != 3'h0) else $error("empty offer");
  AST_DIAG_PAD:
    assert property (i_bus_cycle && i_pi.ctrl == {2'b10, ADR_DIAG}
      |=> o_pi.data[1] == 8'h00 && o_pi.data[0][7:5] == 3'h0)
    else $error("diag pad");
endmodule : sthu_uart_properties
bind sthu_uart sthu_uart_properties sthu_uart_properties_i (
  .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_bus_cycle(i_bus_cycle),
  .i_pi(i_pi), .o_pi(o_pi), .i_rxd(i_rxd), .o_txd(o_txd),
  .o_txd_oe_n(o_txd_oe_n));

// ---- test/sthu_partner.sv ----
/* Remote serial device, 8N1, BIT clocks a bit.
   Assumes the line idles at mark when released. */
`timescale 1ns/1ps
module sthu_partner #(parameter int BIT = 100) (
  input wire logic i_clk, // Bench clock
  input wire logic i_txd, // Line from device
  output logic o_rxd // Line to device
);
  logic [7:0] rx_q[$];
  logic [7:0] sh;
  initial o_rxd = 1'b1;
  task automatic send(input logic [7:0] b, input logic stp);
    logic [9:0] f;
    f = {stp, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      o_rxd = f[i];
      repeat (BIT) @(negedge i_clk);
    end
    o_rxd = 1'b1;
    repeat (BIT) @(negedge i_clk);
  endtask : send
  always begin
    @(negedge i_txd);
    repeat (BIT / 2) @(negedge i_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(negedge i_clk);
      sh[i] = i_txd;
    end
    repeat (BIT) @(negedge i_clk);
    rx_q.push_back(sh);
  end
endmodule : sthu_partner

// ---- test/sthu_uart_tb_top.sv ----
/* Bench of sthu_uart: registers, init, send, receive, errors, flow.
   Assumes sthu_partner at clock / 100 once the divisor is set. */
`timescale 1ns/1ps
module sthu_uart_tb_top import sthu_pkg::*;;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic bcyc = 1'b0;
  logic rxd, txd, oe_n, line;
  sthu_pi_out_t pi = '0;
  sthu_pi_in_t po;
  logic [15:0] v;
  int failures = 0;
  int n_checks = 0;
  logic [5:0] ra[6] = '{6'h21, 6'h22, 6'h23, 6'h12, 6'h06, 6'h05};
  logic [15:0] rd[6] = '{16'h3, 16'h3, 16'h3, 16'h80, 16'h0, 16'h0};
  int cnt[3] = '{1, 5, 1};
  int fst[3] = '{0, 1, 6};
  always #20 clk = ~clk;
  assign line = oe_n ? 1'b1 : txd;
  sthu_uart sthu_uart_i (.i_core_clk(clk), .i_resetn(rstn),
    .i_bus_cycle(bcyc), .i_pi(pi), .o_pi(po), .i_rxd(rxd), .o_txd(txd),
    .o_txd_oe_n(oe_n));
  sthu_partner sthu_partner_i (.i_clk(clk), .i_txd(line), .o_rxd(rxd));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic [7:0] c);
    @(negedge clk);
    pi.ctrl = c;
    bcyc = 1'b1;
    @(negedge clk);
    bcyc = 1'b0;
  endtask : bus
  // Register access; the value shown is kept before handshake mode returns
  task automatic rw(input logic [6:0] a, input logic [15:0] d);
    {pi.data[1], pi.data[0]} = d;
    bus({1'b1, a});
    v = {po.data[1], po.data[0]};
    pi.ctrl = 8'h00;
  endtask : rw
  task automatic poll(input int b, input logic e);
    int k;
    k = 0;
    do begin
      bus(8'h00);
      k++;
    end while (po.ser_stat[b] !== e && k < 40);
    chk(16'(po.ser_stat[b]), 16'(e));
  endtask : poll
  task automatic init();
    pi.ser_ctrl = 8'h04;
    bus(8'h00);
    bus(8'h00);
    chk(16'(po.ser_stat), 16'h0004);
    pi.ser_ctrl = 8'h00;
    bus(8'h00);
    bus(8'h00);
    chk(16'(po.ser_stat), 16'h0000);
  endtask : init
  task automatic wait_q(input int n);
    int k;
    k = 0;
    while (sthu_partner_i.rx_q.size() < n && k < 9000) begin
      @(negedge clk);
      k++;
    end
    chk(16'(sthu_partner_i.rx_q.size()), 16'(n));
  endtask : wait_q
  task automatic stop_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    stop_test();
  end
  initial begin
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    foreach (ra[i]) begin
      rw({1'b0, ra[i]}, 16'h0000);
      chk(v, rd[i]);
    end
    $display("test defaults done");
    rw(7'h60, 16'h00FF);
    rw(7'h63, 16'h0005);
    rw(7'h52, 16'h0006);
    init();
    pi.data = 40'hC35AA53C81;
    pi.ser_ctrl = 8'h51;
    poll(0, 1'b1);
    wait_q(5);
    for (int i = 0; i < 5; i++) begin
      chk(16'(sthu_partner_i.rx_q[i]), 16'(pi.data[i]));
    end
    sthu_partner_i.rx_q.delete();
    $display("test send done");
    for (int i = 0; i < 7; i++) begin
      sthu_partner_i.send(8'(8'h40 + i), 1'b1);
    end
    for (int i = 0; i < 3; i++) begin
      poll(1, ~pi.ser_ctrl[1]);
      chk(16'(po.ser_stat[6:4]), 16'(cnt[i]));
      chk(16'(po.data[0]), 16'(8'h40 + fst[i]));
      chk(16'(po.ser_stat[3]), 16'(i == 0));
      pi.ser_ctrl[1] = po.ser_stat[1];
    end
    $display("test receive done");
    sthu_partner_i.send(8'h55, 1'b0);
    rw(7'h06, 16'h0000);
    chk(v, 16'h0004);
    chk(16'(po.ser_stat[1]), 16'(pi.ser_ctrl[1]));
    $display("test errors done");
    rw(7'h62, 16'h000A);
    init();
    sthu_partner_i.send(8'h13, 1'b1);
    pi.data[1:0] = 16'hB2A1;
    pi.ser_ctrl = 8'h21;
    poll(0, 1'b1);
    repeat (3000) @(negedge clk);
    chk(16'(sthu_partner_i.rx_q.size()), 16'h0000);
    sthu_partner_i.send(8'h11, 1'b1);
    wait_q(2);
    chk(16'(sthu_partner_i.rx_q[1]), 16'h00B2);
    $display("test flow done");
    rw(7'h62, 16'h0024);
    pi.ser_ctrl = 8'h04;
    bus(8'h04);
    chk({po.stat, po.ser_stat}, 16'h0100);
    bus(8'h04);
    chk({po.stat, po.ser_stat}, 16'h0400);
    chk(16'(oe_n), 16'h0000);
    $display("test format done");
    stop_test();
  end
endmodule : sthu_uart_tb_top
